/* inc/uesf_pkg.sv */
// Function
// - Direction bit acts only on control endpoints; ignored for other types.
// - On control endpoints, direction bit selects data and status stage direction.
// - Bank-one flag exists only for endpoints 4 to 6 with ping-pong active.
// - Bank-one flag sets when a complete OUT packet lands in bank one.
// - Bank-one flag setting raises the endpoint interrupt when enabled.
// - While bank-one flag set, further OUT packets to bank one get NAK, except isochronous.
// - Packet-ready with empty buffer sends a zero-length IN packet.
// - Packet-ready clears on send for isochronous, on host ACK otherwise.
// - Clearing packet-ready raises the endpoint interrupt when enabled.
// - After STALL sent on request, set stall-sent flag for non-isochronous types.
// - Endpoint type field: 00 control, 01 isochronous, 10 bulk, 11 interrupt.
package uesf_pkg;

   // ----------------------------------------
   // Register address and bit positions
   // ----------------------------------------
   localparam logic [7:0] ENDPOINT_STATUS_ADDR = 8'hce;
   localparam int         BIT_DIR              = 7;
   localparam int         BIT_OUT_B1           = 6;
   localparam int         BIT_STALL_RQ         = 5;
   localparam int         BIT_IN_READY         = 4;
   localparam int         BIT_STALL_SENT       = 3;
   localparam logic [7:0] ENDPOINT_STATUS_RST  = 8'h00;
   localparam logic [3:0] PINGPONG_EP_LO       = 4'h4;
   localparam logic [3:0] PINGPONG_EP_HI       = 4'h6;

   // ----------------------------------------
   // Endpoint type encoding
   // ----------------------------------------
   typedef enum logic [1:0] {
      EPT_CONTROL = 2'h0,
      EPT_ISO     = 2'h1,
      EPT_BULK    = 2'h2,
      EPT_INTR    = 2'h3
   } uesf_endpoint_type_e;

   // ----------------------------------------
   // Bus-side events from the serial engine
   // ----------------------------------------
   typedef struct packed {
      logic setup_rx;     // SETUP token received
      logic out_b1_done;  // Complete OUT packet stored in bank one
      logic in_sent;      // IN packet transmitted
      logic in_acked;     // Host acknowledged IN packet
      logic stall_sent;   // STALL handshake sent
   } uesf_sie_ev_s;

endpackage : uesf_pkg

/* verilog/uesf_setclr.sv */
`timescale 1ns/1ps
// Sticky flag, hardware set, software clear; set wins
module uesf_setclr (
   // Clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // Controls
   input  wire logic set_i,
   input  wire logic clr_i,
   // State
   output logic      flag_r
);
   always_ff @(posedge clk) begin
      if (sys_rst)    flag_r <= 1'b0;
      else if (set_i) flag_r <= 1'b1;
      else if (clr_i) flag_r <= 1'b0;
   end
endmodule : uesf_setclr

/* verilog/uesf_status.sv */
`timescale 1ns/1ps
module uesf_status (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   // Special-function register port
   input  wire logic [7:0]            sfr_addr,
   input  wire logic                  sfr_wr,
   input  wire logic [7:0]            sfr_wdata,
   output logic [7:0]                 sfr_rdata,
   // Endpoint configuration
   input  wire logic [3:0]            ep_num,
   input  wire uesf_pkg::uesf_endpoint_type_e endpoint_type,
   input  wire logic                  pingpong_en,
   input  wire logic                  ep_int_en,
   input  wire logic                  in_buf_empty,
   // Serial engine events
   input  wire uesf_pkg::uesf_sie_ev_s sie_ev,
   // Serial engine controls
   output logic                       ctrl_dir_in,
   output logic                       out_b1_nak,
   output logic                       in_send_req,
   output logic                       in_send_zlp,
   output logic                       stall_req_o,
   output logic                       endpoint_interrupt
);
   import uesf_pkg::*;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire wr_hit   = sfr_wr && (sfr_addr == ENDPOINT_STATUS_ADDR);
   wire is_ctrl  = (endpoint_type == EPT_CONTROL);
   wire is_iso   = (endpoint_type == EPT_ISO);
   // Bank one only on ping-pong endpoints
   wire b1_exist = pingpong_en && (ep_num >= PINGPONG_EP_LO) && (ep_num <= PINGPONG_EP_HI);

   logic dir_r;
   logic out_b1_r;
   logic stall_rq_r;
   logic in_rdy_r;
   logic stall_sent_r;

   // ----------------------------------------
   // Flag events
   // ----------------------------------------
   wire b1_set    = b1_exist && sie_ev.out_b1_done;
   // Firmware clears by writing zero
   wire b1_clr    = (wr_hit && !sfr_wdata[BIT_OUT_B1]) || !b1_exist;
   // Isochronous clears on send, others on host ACK
   wire rdy_done  = in_rdy_r && (is_iso ? sie_ev.in_sent : sie_ev.in_acked);
   wire rdy_set   = wr_hit && sfr_wdata[BIT_IN_READY];
   wire ss_set    = sie_ev.stall_sent && stall_rq_r && !is_iso;
   wire ss_clr    = wr_hit && !sfr_wdata[BIT_STALL_SENT];

   uesf_setclr u_b1 (
      .clk     (clk),
      .sys_rst (sys_rst),
      .set_i   (b1_set),
      .clr_i   (b1_clr),
      .flag_r  (out_b1_r)
   );

   uesf_setclr u_ss (
      .clk     (clk),
      .sys_rst (sys_rst),
      .set_i   (ss_set),
      .clr_i   (ss_clr),
      .flag_r  (stall_sent_r)
   );

   // ----------------------------------------
   // Firmware-owned bits
   // ----------------------------------------
   // SETUP clears stall request; it beats a same-cycle write
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dir_r      <= 1'b0;
         stall_rq_r <= 1'b0;
      end else begin
         if (wr_hit) dir_r <= sfr_wdata[BIT_DIR];
         if (sie_ev.setup_rx) stall_rq_r <= 1'b0;
         else if (wr_hit) stall_rq_r <= sfr_wdata[BIT_STALL_RQ];
      end
   end

   // Hardware clear wins; no resend of a packet already gone
   always_ff @(posedge clk) begin
      if (sys_rst)       in_rdy_r <= 1'b0;
      else if (rdy_done) in_rdy_r <= 1'b0;
      else if (rdy_set)  in_rdy_r <= 1'b1;
   end

   // Interrupt pulse on bank-one fill or packet-ready release
   always_ff @(posedge clk) begin
      if (sys_rst) endpoint_interrupt <= 1'b0;
      else         endpoint_interrupt <= ep_int_en && (b1_set || rdy_done);
   end

   // ----------------------------------------
   // Outputs to the serial engine
   // ----------------------------------------
   assign ctrl_dir_in = is_ctrl && dir_r;
   assign out_b1_nak  = out_b1_r && !is_iso;
   assign in_send_req = in_rdy_r;
   assign in_send_zlp = in_rdy_r && in_buf_empty;
   assign stall_req_o = stall_rq_r;

   // Read view, zeros in unimplemented bits
   always_ff @(posedge clk) begin
      if (sys_rst) sfr_rdata <= ENDPOINT_STATUS_RST;
      else         sfr_rdata <= {dir_r, out_b1_r, stall_rq_r, in_rdy_r, stall_sent_r, 3'h0};
   end

endmodule : uesf_status

/* tb/uesf_host_model.sv */
`timescale 1ns/1ps
// Bus-side event source, one-cycle pulses
module uesf_host_model (
   // Clock and events
   input  wire logic             clk,
   output uesf_pkg::uesf_sie_ev_s sie_ev
);
   import uesf_pkg::*;
   initial sie_ev = '0;
   // Launch off the falling edge so the block samples a clean pulse
   task automatic send(input uesf_sie_ev_s e);
      @(negedge clk) sie_ev = e;
      @(negedge clk) sie_ev = '0;
   endtask : send
endmodule : uesf_host_model

/* tb/uesf_monitor.sv */
`timescale 1ns/1ps
// Port checker for the status flags
module uesf_monitor
   import uesf_pkg::*;
(
   // Clock, reset and register port
   input wire logic         clk, sys_rst, sfr_wr,
   input wire logic [7:0]   sfr_addr, sfr_wdata, sfr_rdata,
   // Configuration and events
   input wire logic [3:0]   ep_num,
   input wire uesf_endpoint_type_e endpoint_type,
   input wire logic         pingpong_en, ep_int_en, in_buf_empty,
   input wire uesf_sie_ev_s sie_ev,
   // Controls to the serial engine
   input wire logic         ctrl_dir_in, out_b1_nak, in_send_req, in_send_zlp, stall_req_o, endpoint_interrupt
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Ping-pong capable endpoint selected
   wire pp  = pingpong_en && ep_num >= 4'h4 && ep_num <= 4'h6;
   wire iso = endpoint_type == EPT_ISO;
   wire wdir = sfr_wr && sfr_addr == ENDPOINT_STATUS_ADDR && sfr_wdata[BIT_DIR];
   a_dir_ctrl_only: assert property (ctrl_dir_in |-> endpoint_type == EPT_CONTROL) else $error("dir");
   a_dir_write_takes: assert property (wdir ##1 endpoint_type == EPT_CONTROL |-> ctrl_dir_in) else $error("dw");
   a_b1_only_pp: assert property (out_b1_nak |-> pp) else $error("b1 pp");
   a_b1_set_nak: assert property (sie_ev.out_b1_done && pp && !iso ##1 pp && !iso |-> out_b1_nak) else $error("b1");
   a_b1_irq: assert property ($rose(out_b1_nak) && $stable(endpoint_type) && $past(ep_int_en) |-> endpoint_interrupt) else $error("b1 irq");
   a_rdy_clear: assert property (in_send_req && (iso ? sie_ev.in_sent : sie_ev.in_acked) |=> !in_send_req) else $error("rc");
   a_rdy_hold: assert property (in_send_req && !sie_ev.in_acked && !sie_ev.setup_rx && !iso |=> in_send_req) else $error("rh");
   a_rdy_irq: assert property ($fell(in_send_req) && $past(ep_int_en) |-> endpoint_interrupt) else $error("ri");
   a_zlp_empty: assert property (in_send_req && in_buf_empty |-> in_send_zlp) else $error("zlp");
   a_setup_unstall: assert property (sie_ev.setup_rx |=> !stall_req_o) else $error("stall");
   // Main scenarios reached
   c_in_ack: cover property (in_send_req && sie_ev.in_acked);
   c_b1_irq: cover property (out_b1_nak && endpoint_interrupt);
   c_setup: cover property (sie_ev.setup_rx && stall_req_o);
endmodule : uesf_monitor
bind uesf_status uesf_monitor uesf_monitor_inst (.*);

/* tb/testbench.sv */
`timescale 1ns/1ps
// Status flag bench
module testbench;
   import uesf_pkg::*;
   logic         clk = 0, sys_rst = 1, sfr_wr = 0, pingpong_en = 1, ep_int_en = 1, in_buf_empty = 1;
   logic [7:0]   sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
   logic [3:0]   ep_num = 4'h6;
   uesf_endpoint_type_e endpoint_type = EPT_BULK;
   uesf_sie_ev_s sie_ev;
   logic         ctrl_dir_in, out_b1_nak, in_send_req, in_send_zlp, stall_req_o, endpoint_interrupt;
   int           bad_count = 0, n_checks = 0;
   uesf_status uesf_status_inst (.*);
   uesf_host_model uesf_host_model_inst (.clk(clk), .sie_ev(sie_ev));
   initial forever #4 clk = ~clk;
   task automatic chk(string n, logic [7:0] g, logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic test_done;
      if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : test_done
   // Firmware write, one strobe cycle
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(negedge clk) {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
      @(negedge clk) sfr_wr = 0;
   endtask : wr
   task automatic ev(uesf_sie_ev_s e);
      uesf_host_model_inst.send(e);
   endtask : ev
   // IN handshake: bulk waits for ack, iso clears on send
   task automatic t_in;
      wr(ENDPOINT_STATUS_ADDR, 8'h10);
      chk("zlp", {in_send_req, in_send_zlp}, 8'h03);
      ev(5'h04);
      chk("nak", in_send_req, 8'h01);
      ev(5'h02);
      chk("ack", {in_send_req, endpoint_interrupt}, 8'h01);
      endpoint_type = EPT_ISO;
      ep_int_en = 1'b0;
      in_buf_empty = 1'b0;
      wr(ENDPOINT_STATUS_ADDR, 8'h10);
      chk("full", in_send_zlp, 8'h00);
      ev(5'h04);
      chk("iso", {in_send_req, endpoint_interrupt}, 8'h00);
      endpoint_type = EPT_BULK;
      ep_int_en = 1'b1;
   endtask : t_in
   // Second bank: set, iso exemption, clear, refused endpoint 7
   task automatic t_b1;
      ev(5'h08);
      chk("b1", {out_b1_nak, endpoint_interrupt}, 8'h03);
      endpoint_type = EPT_ISO;
      #1 chk("b1iso", out_b1_nak, 8'h00);
      endpoint_type = EPT_BULK;
      wr(ENDPOINT_STATUS_ADDR, 8'h00);
      chk("b1clr", out_b1_nak, 8'h00);
      ep_num = 4'h7;
      ev(5'h08);
      chk("b1ep7", {out_b1_nak, endpoint_interrupt}, 8'h00);
   endtask : t_b1
   // Direction, unmapped write, stall request and stall sent
   task automatic t_dir;
      endpoint_type = EPT_CONTROL;
      wr(ENDPOINT_STATUS_ADDR, 8'h80);
      chk("dir", ctrl_dir_in, 8'h01);
      endpoint_type = EPT_INTR;
      #1 chk("dirx", ctrl_dir_in, 8'h00);
      wr(8'hcd, 8'h00);
      endpoint_type = EPT_CONTROL;
      #1 chk("unmap", ctrl_dir_in, 8'h01);
      wr(ENDPOINT_STATUS_ADDR, 8'h20);
      chk("stall", {ctrl_dir_in, stall_req_o}, 8'h01);
      ev(5'h01);
      @(negedge clk) chk("sent", sfr_rdata, 8'h28);
      ev(5'h10);
      chk("setup", stall_req_o, 8'h00);
   endtask : t_dir
   // Reset, scenarios, verdict
   initial begin
      repeat (20) @(negedge clk);
      sys_rst = 0;
      @(negedge clk) chk("rst", sfr_rdata, ENDPOINT_STATUS_RST);
      t_in;
      t_b1;
      t_dir;
      test_done;
   end
   // Watchdog well beyond the run length
   initial begin
      #20000;
      bad_count++;
      test_done;
   end
endmodule : testbench
